// [hw/rcs_params.svh]
// constants for the reset cause and power sequencing block
`ifndef RCS_PARAMS_SVH
`define RCS_PARAMS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define RCS_ADDR_STATUS      16'h0740
`define RCS_ADDR_IRQ_STATUS  16'h0760
`define RCS_ADDR_IRQ_MASK    16'h0762

// ----------------------------------------------------------------
// field positions of the cause register
// ----------------------------------------------------------------
`define RCS_BIT_TRAP         15
`define RCS_BIT_ILLEGAL      14
`define RCS_BIT_CFG_MISMATCH 9
`define RCS_BIT_REG_SLEEP    8
`define RCS_BIT_PIN_RESET    7
`define RCS_BIT_SW_RESET     6
`define RCS_BIT_WDT_SOFT     5
`define RCS_BIT_WDT_TIMEOUT  4
`define RCS_BIT_SLEEP_WAKE   3
`define RCS_BIT_IDLE_WAKE    2
`define RCS_BIT_BROWNOUT     1
`define RCS_BIT_POWER_ON     0

// ----------------------------------------------------------------
// masks and reset values
// ----------------------------------------------------------------
`define RCS_STATUS_IMPL      16'hC3FF
`define RCS_FLAG_MASK        16'hC2DF
`define RCS_STATUS_POR_VALUE 16'h0003
`define RCS_ZERO16           16'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RCS_CLK_MHZ          50
`define RCS_POR_DELAY_NS     10000
`define RCS_POR_DELAY_CYC    ((`RCS_POR_DELAY_NS * `RCS_CLK_MHZ + 999) / 1000)
`define RCS_BOR_DELAY_US     100
`define RCS_PWRT_UNIT_MS     2
`define RCS_EVT_HOLD_CYC     4

`endif

// [hw/rcs_pkg.sv]
// types shared by the reset cause and power sequencing block
package rcs_pkg;

    // ----------------------------------------------------------------
    // register port request
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } rcs_bus_req_t;

    // ----------------------------------------------------------------
    // one-cycle cause pulses from the core
    // ----------------------------------------------------------------
    typedef struct packed {
        logic trap_conflict;
        logic illegal_op;
        logic config_mismatch;
        logic sw_reset;
        logic watchdog_timeout;
        logic sleep_wake;
        logic idle_wake;
    } rcs_cause_evt_t;

    // ----------------------------------------------------------------
    // power and reset sequencer
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_SUPPLY    = 3'b000,
        ST_POR_DELAY = 3'b001,
        ST_RUN       = 3'b010,
        ST_BOR_WAIT  = 3'b011,
        ST_BOR_DELAY = 3'b100,
        ST_PWRT      = 3'b101,
        ST_PIN_HOLD  = 3'b110,
        ST_EVT_HOLD  = 3'b111
    } rcs_state_t;

endpackage

// [hw/rcs_reset_cause.sv]
// reset cause register, watchdog enable and power-on hold-off sequencer
//
// Notes on behaviour
// - trap conflict reset sets bit 15, otherwise only a software write sets it
// - illegal opcode, address mode or uninitialised pointer reset sets bit 14
// - bits 13 to 10 always read as zero
// - configuration mismatch reset sets bit 9
// - bit 8 one keeps regulator active in sleep, zero lets it stand by
// - master clear pin reset sets bit 7
// - reset instruction sets bit 6
// - bit 5 one enables the watchdog, zero disables it
// - fuse at one keeps the watchdog enabled whatever bit 5 says
// - watchdog time-out sets bit 4
// - having been in sleep sets bit 3
// - having been in idle sets bit 2
// - software may write each flag either way; setting one causes no reset
// - power-on reset sets bit 0
// - hold in reset until supply good, then a fixed power-on delay
// - the register's reset value depends on the kind of reset
// - brown-out reset sets bit 1
// - after brown-out hold until supply back, brown-out delay, then power-up delay
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "rcs_params.svh"

module rcs_reset_cause #(
    parameter int BOR_DELAY_CYC = `RCS_BOR_DELAY_US * `RCS_CLK_MHZ,
    parameter int PWRT_UNIT_CYC = `RCS_PWRT_UNIT_MS * 1000 * `RCS_CLK_MHZ
) (
    // clock and power-on reset
    input  wire logic                   mclk,
    input  wire logic                   reset,
    // register port
    input  wire rcs_pkg::rcs_bus_req_t  bus_req,
    output logic [15:0]                 rd_data,
    // cause pulses from the core
    input  wire rcs_pkg::rcs_cause_evt_t cause_evt,
    // pins and analog comparators
    input  wire logic                   master_clear_pin_n,
    input  wire logic                   supply_good,
    input  wire logic                   brownout_detect,
    // configuration fuses
    input  wire logic                   watchdog_fuse_enable,
    input  wire logic [2:0]             powerup_timer_select,
    // controls out
    output logic                        device_reset_hold,
    output logic                        watchdog_enable,
    output logic                        regulator_sleep_active,
    output logic                        irq
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
        hit = (a == b);
    endfunction

    function automatic logic [23:0] pwrt_cycles(input logic [2:0] sel);
        // setting zero means no power-up delay at all
        if (sel == 3'h0)
            pwrt_cycles = 24'h000000;
        else
            pwrt_cycles = 24'(PWRT_UNIT_CYC) << (sel - 3'h1);
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] sync_meta;
    logic [2:0] sync_out;
    logic       pin_low_s;
    logic       supply_good_s;
    logic       brownout_s;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            sync_meta <= 3'h4;
            sync_out  <= 3'h4;
        end
        else
        begin
            sync_meta <= {master_clear_pin_n, supply_good, brownout_detect};
            sync_out  <= sync_meta;
        end
    end

    assign pin_low_s     = ~sync_out[2];
    assign supply_good_s = sync_out[1];
    assign brownout_s    = sync_out[0];

    // ----------------------------------------------------------------
    // register port decode
    // ----------------------------------------------------------------
    logic        wr_status;
    logic        wr_irq_status;
    logic        wr_irq_mask;
    logic [15:0] status;
    logic [15:0] irq_status;
    logic [15:0] irq_mask;
    logic [15:0] cause_set;
    logic [15:0] next_status;

    assign wr_status     = bus_req.wr && hit(bus_req.addr, `RCS_ADDR_STATUS);
    assign wr_irq_status = bus_req.wr && hit(bus_req.addr, `RCS_ADDR_IRQ_STATUS);
    assign wr_irq_mask   = bus_req.wr && hit(bus_req.addr, `RCS_ADDR_IRQ_MASK);

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    rcs_pkg::rcs_state_t state;
    rcs_pkg::rcs_state_t next_state;
    logic [23:0]         delay_count;
    logic [23:0]         next_delay;
    logic                core_reset_req;
    logic                wdt_trip;

    assign wdt_trip       = cause_evt.watchdog_timeout && watchdog_enable;
    assign core_reset_req = cause_evt.trap_conflict || cause_evt.illegal_op
                          || cause_evt.config_mismatch || cause_evt.sw_reset || wdt_trip;

    always_comb
    begin
        next_state = state;
        next_delay = (delay_count != 24'h000000) ? delay_count - 24'h000001 : delay_count;
        case (state)
            rcs_pkg::ST_SUPPLY:
                if (supply_good_s)
                begin
                    next_state = rcs_pkg::ST_POR_DELAY;
                    next_delay = 24'(`RCS_POR_DELAY_CYC);
                end
            rcs_pkg::ST_POR_DELAY:
                if (delay_count == 24'h000000)
                    next_state = rcs_pkg::ST_RUN;
            rcs_pkg::ST_RUN:
                if (brownout_s)
                    next_state = rcs_pkg::ST_BOR_WAIT;
                else if (pin_low_s)
                    next_state = rcs_pkg::ST_PIN_HOLD;
                else if (core_reset_req)
                begin
                    next_state = rcs_pkg::ST_EVT_HOLD;
                    next_delay = 24'(`RCS_EVT_HOLD_CYC);
                end
            rcs_pkg::ST_BOR_WAIT:
                if (!brownout_s)
                begin
                    next_state = rcs_pkg::ST_BOR_DELAY;
                    next_delay = 24'(BOR_DELAY_CYC);
                end
            rcs_pkg::ST_BOR_DELAY:
                if (brownout_s)
                    next_state = rcs_pkg::ST_BOR_WAIT;
                else if (delay_count == 24'h000000)
                begin
                    next_state = rcs_pkg::ST_PWRT;
                    next_delay = pwrt_cycles(powerup_timer_select);
                end
            rcs_pkg::ST_PWRT:
                if (brownout_s)
                    next_state = rcs_pkg::ST_BOR_WAIT;
                else if (delay_count == 24'h000000)
                    next_state = rcs_pkg::ST_RUN;
            rcs_pkg::ST_PIN_HOLD:
                if (brownout_s)
                    next_state = rcs_pkg::ST_BOR_WAIT;
                else if (!pin_low_s)
                begin
                    next_state = rcs_pkg::ST_EVT_HOLD;
                    next_delay = 24'(`RCS_EVT_HOLD_CYC);
                end
            rcs_pkg::ST_EVT_HOLD:
                if (brownout_s)
                    next_state = rcs_pkg::ST_BOR_WAIT;
                else if (delay_count == 24'h000000)
                    next_state = rcs_pkg::ST_RUN;
            default:
                next_state = rcs_pkg::ST_SUPPLY;
        endcase
    end

    // the reset hold is registered so the core sees a clean level
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state             <= rcs_pkg::ST_SUPPLY;
            delay_count       <= 24'h000000;
            device_reset_hold <= 1'b1;
        end
        else
        begin
            state             <= next_state;
            delay_count       <= next_delay;
            device_reset_hold <= (next_state != rcs_pkg::ST_RUN);
        end
    end

    // ----------------------------------------------------------------
    // cause register
    // ----------------------------------------------------------------
    always_comb
    begin
        cause_set                        = `RCS_ZERO16;
        cause_set[`RCS_BIT_TRAP]         = cause_evt.trap_conflict;
        cause_set[`RCS_BIT_ILLEGAL]      = cause_evt.illegal_op;
        cause_set[`RCS_BIT_CFG_MISMATCH] = cause_evt.config_mismatch;
        cause_set[`RCS_BIT_PIN_RESET]    = pin_low_s;
        cause_set[`RCS_BIT_SW_RESET]     = cause_evt.sw_reset;
        cause_set[`RCS_BIT_WDT_TIMEOUT]  = wdt_trip;
        cause_set[`RCS_BIT_SLEEP_WAKE]   = cause_evt.sleep_wake;
        cause_set[`RCS_BIT_IDLE_WAKE]    = cause_evt.idle_wake;
        cause_set[`RCS_BIT_BROWNOUT]     = brownout_s;
    end

    always_comb
    begin
        // a write may set or clear any flag; a hardware cause in the same cycle wins
        if (wr_status)
            next_status = (bus_req.wdata & `RCS_STATUS_IMPL) | cause_set;
        else
            next_status = status | cause_set;
    end

    // only power-on reloads the register, with 16'h0003; other resets just add their flag
    always_ff @(posedge mclk)
    begin
        if (reset)
            status <= `RCS_STATUS_POR_VALUE;
        else
            status <= next_status & `RCS_STATUS_IMPL;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            watchdog_enable        <= 1'b0;
            regulator_sleep_active <= 1'b0;
        end
        else
        begin
            watchdog_enable        <= watchdog_fuse_enable
                                    || next_status[`RCS_BIT_WDT_SOFT];
            regulator_sleep_active <= next_status[`RCS_BIT_REG_SLEEP];
        end
    end

    // ----------------------------------------------------------------
    // interrupt status and mask
    // ----------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (reset)
            irq_status <= `RCS_ZERO16;
        else if (wr_irq_status)
            irq_status <= (irq_status & ~bus_req.wdata) | cause_set;
        else
            irq_status <= irq_status | cause_set;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            irq_mask <= `RCS_ZERO16;
        else if (wr_irq_mask)
            irq_mask <= bus_req.wdata & `RCS_FLAG_MASK;
    end

    assign irq = |(irq_status & irq_mask & `RCS_FLAG_MASK);

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (reset)
            rd_data <= `RCS_ZERO16;
        else if (!bus_req.rd)
            rd_data <= `RCS_ZERO16;
        else if (hit(bus_req.addr, `RCS_ADDR_STATUS))
            rd_data <= status & `RCS_STATUS_IMPL;
        else if (hit(bus_req.addr, `RCS_ADDR_IRQ_STATUS))
            rd_data <= irq_status & `RCS_FLAG_MASK;
        else if (hit(bus_req.addr, `RCS_ADDR_IRQ_MASK))
            rd_data <= irq_mask;
        else
            rd_data <= `RCS_ZERO16;
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    property p_reserved_zero;
        bus_req.rd && hit(bus_req.addr, `RCS_ADDR_STATUS) |=> rd_data[13:10] == 4'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

    property p_trap_flag;
        cause_evt.trap_conflict |=> status[`RCS_BIT_TRAP] ##1 device_reset_hold || !$past(state == rcs_pkg::ST_RUN, 2);
    endproperty
    a_trap_flag: assert property (p_trap_flag) else $error("trap flag not set");

    property p_illegal_flag;
        cause_evt.illegal_op |=> status[`RCS_BIT_ILLEGAL];
    endproperty
    a_illegal_flag: assert property (p_illegal_flag) else $error("illegal flag not set");

    property p_mismatch_flag;
        cause_evt.config_mismatch |=> status[`RCS_BIT_CFG_MISMATCH];
    endproperty
    a_mismatch_flag: assert property (p_mismatch_flag) else $error("mismatch flag not set");

    property p_regulator;
        wr_status |=> regulator_sleep_active == $past(bus_req.wdata[`RCS_BIT_REG_SLEEP]);
    endproperty
    a_regulator: assert property (p_regulator) else $error("regulator control wrong");

    property p_fuse_forces_wdt;
        watchdog_fuse_enable && wr_status && !bus_req.wdata[`RCS_BIT_WDT_SOFT]
            |=> watchdog_enable;
    endproperty
    a_fuse_forces_wdt: assert property (p_fuse_forces_wdt) else $error("fuse ignored");

    property p_soft_wdt_off;
        !watchdog_fuse_enable && wr_status && !bus_req.wdata[`RCS_BIT_WDT_SOFT]
            |=> !watchdog_enable;
    endproperty
    a_soft_wdt_off: assert property (p_soft_wdt_off) else $error("watchdog not disabled");

    property p_write_no_reset;
        state == rcs_pkg::ST_RUN && wr_status && !core_reset_req && !brownout_s && !pin_low_s
            |=> !device_reset_hold;
    endproperty
    a_write_no_reset: assert property (p_write_no_reset) else $error("write caused reset");

    property p_flags_keep;
        !wr_status |=> (status & $past(status) & `RCS_FLAG_MASK) == ($past(status) & `RCS_FLAG_MASK);
    endproperty
    a_flags_keep: assert property (p_flags_keep) else $error("flag lost");

    property p_brownout;
        $rose(brownout_detect) ##1 brownout_detect ##1 brownout_detect
            |-> ##1 status[`RCS_BIT_BROWNOUT] && device_reset_hold;
    endproperty
    a_brownout: assert property (p_brownout) else $error("brown-out not handled");

    property p_bor_hold;
        state == rcs_pkg::ST_BOR_WAIT |=> device_reset_hold [*2];
    endproperty
    a_bor_hold: assert property (p_bor_hold) else $error("released during brown-out");

    property p_supply_hold;
        state == rcs_pkg::ST_SUPPLY |=> device_reset_hold;
    endproperty
    a_supply_hold: assert property (p_supply_hold) else $error("released before supply good");

    property p_wdt_flag;
        cause_evt.watchdog_timeout && watchdog_enable |=> status[`RCS_BIT_WDT_TIMEOUT];
    endproperty
    a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag not set");

    c_por_release:  cover property (state == rcs_pkg::ST_POR_DELAY ##1 state == rcs_pkg::ST_RUN);
    c_bor_cycle:    cover property (state == rcs_pkg::ST_PWRT ##1 state == rcs_pkg::ST_RUN);
    c_sw_reset:     cover property (state == rcs_pkg::ST_RUN && cause_evt.sw_reset);
    c_irq:          cover property ($rose(irq));

endmodule

`default_nettype wire

// [tb/tb_reset_cause_status_logic.sv]
// self-checking bench for the reset cause and power sequencing block
`timescale 1ns/100ps
`default_nettype none
`include "rcs_params.svh"

module tb_reset_cause_status_logic;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic                    mclk;
    logic                    reset;
    rcs_pkg::rcs_bus_req_t   bus_req;
    logic [15:0]             rd_data;
    rcs_pkg::rcs_cause_evt_t cause_evt;
    logic                    master_clear_pin_n;
    logic                    supply_good;
    logic                    brownout_detect;
    logic                    watchdog_fuse_enable;
    logic [2:0]              powerup_timer_select;
    logic                    device_reset_hold;
    logic                    watchdog_enable;
    logic                    regulator_sleep_active;
    logic                    irq;
    logic [15:0]             exp_q[$];
    logic                    rd_flag;
    logic [15:0]             v;
    int                      fails;
    int                      check_count;
    int                      cycles;
    int                      seed;
    int                      n;
    int                      bitpos[7] = '{15, 14, 9, 6, 4, 3, 2};

    // ----------------------------------------------------------------
    // design under test, short delays so the brown-out path fits the run
    // ----------------------------------------------------------------
    rcs_reset_cause #(
        .BOR_DELAY_CYC (8),
        .PWRT_UNIT_CYC (4)
    ) dut (
        .mclk                   (mclk),
        .reset                  (reset),
        .bus_req                (bus_req),
        .rd_data                (rd_data),
        .cause_evt              (cause_evt),
        .master_clear_pin_n     (master_clear_pin_n),
        .supply_good            (supply_good),
        .brownout_detect        (brownout_detect),
        .watchdog_fuse_enable   (watchdog_fuse_enable),
        .powerup_timer_select   (powerup_timer_select),
        .device_reset_hold      (device_reset_hold),
        .watchdog_enable        (watchdog_enable),
        .regulator_sleep_active (regulator_sleep_active),
        .irq                    (irq)
    );

    initial mclk = 1'b0;
    always #10 mclk = ~mclk;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one strobe cycle, then idle; the next call waits a fresh edge
    task automatic bus(input logic [15:0] a, input logic [15:0] d, input logic w, input logic r);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        bus(a, d, 1'b1, 1'b0);
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        exp_q.push_back(exp);
        bus(a, 16'h0000, 1'b0, 1'b1);
    endtask

    task automatic settle(input int k);
        repeat (k) @(posedge mclk);
        @(negedge mclk);
    endtask

    // bounded so a stuck hold cannot hang the run
    task automatic count_hold(output int k);
        k = 0;
        @(negedge mclk);
        while (device_reset_hold !== 1'b0 && k < 400)
        begin
            k++;
            @(negedge mclk);
        end
    endtask

    task automatic tally_and_finish;
        if (fails == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // read data monitor: one cycle after each read strobe
    // ----------------------------------------------------------------
    always @(negedge mclk)
    begin
        if (rd_flag)
            check("rd_data", rd_data, exp_q.pop_front());
        rd_flag = bus_req.rd;
    end

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            tally_and_finish();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        seed = 78;
        fails = 0;
        check_count = 0;
        cycles = 0;
        rd_flag = 1'b0;
        reset = 1'b1;
        bus_req = '0;
        cause_evt = '0;
        master_clear_pin_n = 1'b1;
        supply_good = 1'b0;
        brownout_detect = 1'b0;
        watchdog_fuse_enable = 1'b0;
        powerup_timer_select = 3'h2;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        settle(50);
        check("hold_no_supply", 16'(device_reset_hold), 16'h0001);
        @(posedge mclk);
        supply_good <= 1'b1;
        settle(450);
        check("hold_por_delay", 16'(device_reset_hold), 16'h0001);
        count_hold(n);
        check("por_release", 16'(n > 0 && n < 80), 16'h0001);
        rd(`RCS_ADDR_STATUS, 16'h0003);
        rd(`RCS_ADDR_IRQ_STATUS, 16'h0000);
        rd(`RCS_ADDR_IRQ_MASK, 16'h0000);
        rd(16'h0744, 16'h0000);
        // software sets every flag; no reset may follow
        wr(`RCS_ADDR_STATUS, 16'hFFFF);
        rd(`RCS_ADDR_STATUS, 16'hC3FF);
        settle(1);
        check("hold_after_set", 16'(device_reset_hold), 16'h0000);
        check("wdt_on", 16'(watchdog_enable), 16'h0001);
        check("vreg_on", 16'(regulator_sleep_active), 16'h0001);
        wr(`RCS_ADDR_STATUS, 16'h0000);
        rd(`RCS_ADDR_STATUS, 16'h0000);
        settle(1);
        check("wdt_off", 16'(watchdog_enable), 16'h0000);
        check("vreg_off", 16'(regulator_sleep_active), 16'h0000);
        @(posedge mclk);
        watchdog_fuse_enable <= 1'b1;
        settle(2);
        check("wdt_fuse", 16'(watchdog_enable), 16'h0001);
        @(posedge mclk);
        watchdog_fuse_enable <= 1'b0;
        for (int r = 0; r < 4; r++)
        begin
            v = 16'($random(seed));
            wr(`RCS_ADDR_STATUS, v);
            rd(`RCS_ADDR_STATUS, v & 16'hC3FF);
        end
        // each cause event on its own, watchdog enabled so time-out counts
        for (int i = 0; i < 7; i++)
        begin
            wr(`RCS_ADDR_STATUS, 16'h0020);
            @(posedge mclk);
            @(posedge mclk);
            cause_evt <= rcs_pkg::rcs_cause_evt_t'(7'h40 >> i);
            @(posedge mclk);
            cause_evt <= '0;
            count_hold(n);
            check("event_hold", 16'(n), (i < 5) ? 16'(`RCS_EVT_HOLD_CYC + 1) : 16'h0000);
            rd(`RCS_ADDR_STATUS, 16'h0020 | (16'h0001 << bitpos[i]));
        end
        // interrupt: masked, unmasked, cleared
        settle(1);
        check("irq_masked", 16'(irq), 16'h0000);
        wr(`RCS_ADDR_IRQ_MASK, 16'h0040);
        settle(0);
        check("irq_raised", 16'(irq), 16'h0001);
        rd(`RCS_ADDR_IRQ_MASK, 16'h0040);
        wr(`RCS_ADDR_IRQ_STATUS, 16'hFFFF);
        settle(0);
        check("irq_cleared", 16'(irq), 16'h0000);
        rd(`RCS_ADDR_IRQ_STATUS, 16'h0000);
        wr(`RCS_ADDR_IRQ_MASK, 16'hFFFF);
        rd(`RCS_ADDR_IRQ_MASK, 16'hC2DF);
        // master clear pin
        wr(`RCS_ADDR_STATUS, 16'h0020);
        @(posedge mclk);
        master_clear_pin_n <= 1'b0;
        repeat (3) @(posedge mclk);
        master_clear_pin_n <= 1'b1;
        settle(3);
        check("hold_pin", 16'(device_reset_hold), 16'h0001);
        count_hold(n);
        rd(`RCS_ADDR_STATUS, 16'h00A0);
        // brown-out: supply back, then brown-out and power-up delays
        wr(`RCS_ADDR_STATUS, 16'h0020);
        @(posedge mclk);
        brownout_detect <= 1'b1;
        repeat (4) @(posedge mclk);
        brownout_detect <= 1'b0;
        count_hold(n);
        check("brownout_release", 16'(n >= 16 && n <= 26), 16'h0001);
        rd(`RCS_ADDR_STATUS, 16'h0022);
        settle(3);
        tally_and_finish();
    end

endmodule

`default_nettype wire
